// File: verilog/nv_store_ctrl.sv
`timescale 1ns/1ps
module nv_store_ctrl
  import nv_store_pkg::*;
#(
  parameter int NV_AW = 9
) (
  // Clock and reset
  input  wire logic              MCLK,
  input  wire logic              RST,
  // Register access from the serial port
  input  wire logic [ADDR_W-1:0] REG_ADDR,
  input  wire logic              REG_WR,
  input  wire logic [DATA_W-1:0] REG_WDATA,
  input  wire logic              REG_RD,
  output logic      [DATA_W-1:0] REG_RDATA,
  // Device pins and status source
  input  wire logic              NV_LOAD_SEL_N,
  input  wire logic              STATUS_SRC_NV,
  output logic                   STATUS_OUT,
  // Buffer register bank
  output logic      [ADDR_W-1:0] BUF_ADDR,
  input  wire logic [DATA_W-1:0] BUF_RDATA,
  output logic      [DATA_W-1:0] BUF_WDATA,
  output logic                   BUF_WE,
  // Strobes to the rest of the device
  output logic                   COMMIT,
  output logic                   SOFT_RESET
);

  xfer_state_t      state;
  xfer_state_t      next_state;
  logic             save_mode;
  logic             next_save_mode;
  logic             primed;
  logic             next_primed;
  logic [NV_AW-1:0] nv_ptr;
  logic [NV_AW-1:0] next_nv_ptr;
  logic [7:0]       seg_idx;
  logic [7:0]       next_seg_idx;
  logic [6:0]       len;
  logic [6:0]       next_len;
  logic [11:0]      data_addr;
  logic [11:0]      next_data_addr;
  logic [7:0]       csum;
  logic [7:0]       next_csum;
  logic             err;
  logic             next_err;
  logic             save_trig;
  logic             next_save_trig;
  logic             wr_en;
  logic             soft_bit;
  logic             commit_reg;
  logic             next_buf_we;
  logic [11:0]      next_buf_addr;
  logic [7:0]       next_buf_wdata;
  logic             next_commit;
  logic [7:0]       nv_mem [0:(1<<NV_AW)-1];
  logic             load_sel_n;

  pin_filter #(
    .RST_VAL (PIN_RST)
  ) u_load_sel (
    .clk   (MCLK),
    .rst   (RST),
    .pin   (NV_LOAD_SEL_N),
    .level (load_sel_n)
  );

  // Register decode
  wire       hit_state   = (REG_ADDR == REG_STATE);
  wire       hit_error   = (REG_ADDR == REG_ERROR);
  wire       hit_control = (REG_ADDR == REG_CONTROL);
  wire       hit_save    = (REG_ADDR == REG_SAVE);
  wire       hit_commit  = (REG_ADDR == REG_COMMIT);
  wire       idle        = (state == ST_IDLE);
  wire       busy        = !idle;

  // A save needs the write enable; a blocked request leaves the trigger at 0
  wire save_req   = REG_WR && hit_save && REG_WDATA[BIT_SAVE];
  wire start_save = save_req && wr_en && idle;
  // The pin is filtered, so a reload is honoured a few cycles after it falls
  wire load_req   = REG_WR && hit_control && REG_WDATA[BIT_SOFT];
  wire start_load = load_req && !load_sel_n && idle;
  wire host_commit = REG_WR && hit_commit && REG_WDATA[BIT_COMMIT];

  // During a save each buffer byte needs one cycle of address setup
  wire             byte_ready = !save_mode || primed || (state == ST_CHECK);
  wire             step       = busy && byte_ready;
  wire [7:0]       cur_byte   = save_mode ? BUF_RDATA : nv_mem[nv_ptr];
  wire [11:0]      seg_addr   = SEG_BASE + {4'h0, seg_idx};
  wire             nv_full    = &nv_ptr;
  wire             nv_we      = step && save_mode && wr_en;
  wire [7:0]       nv_wdata   = (state == ST_CHECK) ? csum : cur_byte;
  wire             cmd_is_op  = cur_byte[BIT_OPCODE];
  wire             seg_end    = (cur_byte == OP_END);
  wire             seg_update = !save_mode && (cur_byte == OP_IO_UPDATE);
  // Only a reload can compare; a save writes the sum instead
  wire             check_bad  = !save_mode && (cur_byte != csum);

  // Unused upper bits of every register read 0
  wire [7:0] rd_state   = {7'h00, busy};
  wire [7:0] rd_error   = {7'h00, err};
  wire [7:0] rd_control = {6'h00, soft_bit, wr_en};
  wire [7:0] rd_save    = {7'h00, save_trig};
  wire [7:0] rd_mux =
    hit_state   ? rd_state   :
    hit_error   ? rd_error   :
    hit_control ? rd_control :
    hit_save    ? rd_save    :
                  BYTE_RST;

  always_comb begin
    next_state     = state;
    next_save_mode = save_mode;
    next_primed    = primed;
    next_nv_ptr    = nv_ptr;
    next_seg_idx   = seg_idx;
    next_len       = len;
    next_data_addr = data_addr;
    next_csum      = csum;
    next_err       = err;
    next_save_trig = save_trig;
    next_buf_addr  = BUF_ADDR;
    next_buf_wdata = BUF_WDATA;
    next_buf_we    = 1'b0;
    next_commit    = host_commit;
    if (idle) begin
      // A new transfer clears the error left by the last one
      if (start_save || start_load) begin
        next_state     = ST_CMD;
        next_save_mode = start_save;
        next_save_trig = start_save;
        next_primed    = 1'b0;
        next_nv_ptr    = '0;
        next_seg_idx   = 8'h00;
        next_csum      = 8'h00;
        next_err       = 1'b0;
      end
    end else if (!byte_ready) begin
      // Save only: the bank address goes out a cycle before its byte
      next_buf_addr = (state == ST_DATA) ? data_addr : seg_addr;
      next_primed   = 1'b1;
    end else begin
      next_primed = 1'b0;
      next_nv_ptr = nv_ptr + 1'b1;
      if (state != ST_CHECK) begin
        next_csum = csum + cur_byte;
      end
      if (save_mode && (state != ST_DATA)) begin
        next_seg_idx = seg_idx + 8'h01;
      end
      unique case (state)
        ST_CMD: begin
          if (!cmd_is_op) begin
            next_len   = cur_byte[6:0];
            next_state = ST_AHI;
          end else if (seg_end) begin
            next_state = ST_CHECK;
          end else if (seg_update) begin
            next_commit = 1'b1;
          end
        end
        ST_AHI: begin
          next_data_addr = {cur_byte[3:0], data_addr[7:0]};
          next_state     = ST_ALO;
        end
        ST_ALO: begin
          next_data_addr = {data_addr[11:8], cur_byte};
          next_state     = ST_DATA;
        end
        ST_DATA: begin
          if (!save_mode) begin
            next_buf_addr  = data_addr;
            next_buf_wdata = cur_byte;
            next_buf_we    = 1'b1;
          end
          next_data_addr = data_addr + 12'h001;
          next_len       = len - 7'h01;
          if (len == 7'h00) begin
            next_state = ST_CMD;
          end
        end
        ST_CHECK: begin
          // Busy drops after the check byte has been handled, or earlier when the walk runs off the end of memory
          if (check_bad) begin
            next_err = 1'b1;
          end
          next_state     = ST_IDLE;
          next_save_trig = 1'b0;
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
      // Running off the end of memory means the segment lacked its end code
      if (nv_full && (state != ST_CHECK)) begin
        next_err       = 1'b1;
        next_state     = ST_IDLE;
        next_save_trig = 1'b0;
      end
    end
  end

  // Sequencing state
  always_ff @(posedge MCLK) begin
    if (RST) begin
      state     <= ST_IDLE;
      save_mode <= 1'b0;
      primed    <= 1'b0;
      err       <= 1'b0;
      save_trig <= 1'b0;
    end else begin
      state     <= next_state;
      save_mode <= next_save_mode;
      primed    <= next_primed;
      err       <= next_err;
      save_trig <= next_save_trig;
    end
  end

  // Walk pointers and running sum
  always_ff @(posedge MCLK) begin
    if (RST) begin
      nv_ptr    <= '0;
      seg_idx   <= 8'h00;
      len       <= 7'h00;
      data_addr <= 12'h000;
      csum      <= 8'h00;
    end else begin
      nv_ptr    <= next_nv_ptr;
      seg_idx   <= next_seg_idx;
      len       <= next_len;
      data_addr <= next_data_addr;
      csum      <= next_csum;
    end
  end

  // Reload writes reach the bank one cycle after their byte is taken
  always_ff @(posedge MCLK) begin
    if (RST) begin
      BUF_ADDR  <= 12'h000;
      BUF_WDATA <= 8'h00;
      BUF_WE    <= 1'b0;
    end else begin
      BUF_ADDR  <= next_buf_addr;
      BUF_WDATA <= next_buf_wdata;
      BUF_WE    <= next_buf_we;
    end
  end

  // Host and opcode requests in one cycle merge into a single strobe
  always_ff @(posedge MCLK) begin
    if (RST) begin
      commit_reg <= 1'b0;
    end else begin
      commit_reg <= next_commit;
    end
  end

  // Write enable is written by every control write, busy or not
  always_ff @(posedge MCLK) begin
    if (RST) begin
      wr_en <= WR_EN_RST;
    end else if (REG_WR && hit_control) begin
      wr_en <= REG_WDATA[BIT_WR_EN];
    end
  end

  // The soft reload bit reads 1 for one cycle only, then clears itself
  always_ff @(posedge MCLK) begin
    if (RST) begin
      soft_bit   <= 1'b0;
      SOFT_RESET <= 1'b0;
    end else begin
      soft_bit   <= start_load;
      SOFT_RESET <= start_load;
    end
  end

  // Memory contents survive reset on purpose
  always_ff @(posedge MCLK) begin
    if (nv_we) begin
      nv_mem[nv_ptr] <= nv_wdata;
    end
  end

  // Read data holds between reads, so the host may fetch it late
  always_ff @(posedge MCLK) begin
    if (RST) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      REG_RDATA <= rd_mux;
    end
  end

  // The pin lags busy by one cycle
  always_ff @(posedge MCLK) begin
    if (RST) begin
      STATUS_OUT <= 1'b0;
    end else begin
      STATUS_OUT <= STATUS_SRC_NV && busy;
    end
  end

  assign COMMIT = commit_reg;

endmodule // nv_store_ctrl

// File: verilog/nv_store_pkg.sv
// Summary of operation
// - Read-only busy bit shows save/load running
// - Busy flag drives status pin when selected
// - Read-only error bit flags bad transfer
// - Error reads 1 on bad data, else 0
// - Soft reload with load-select low reloads settings
// - Soft reload bit clears itself once started
// - Write enable defaults 0, blocks memory writes
// - Write enable 1 allows saving to memory
// - Writing save trigger starts buffer-to-memory copy
// - Save trigger self-clears when save finishes
// - Command bit7 clear: length+1 bytes, address MSB-first
// - Commit strobe copies buffers to active, self-clears
// - End-of-data code terminates save or load
package nv_store_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;

  // Register map
  localparam logic [11:0] REG_STATE   = 12'hB00;
  localparam logic [11:0] REG_ERROR   = 12'hB01;
  localparam logic [11:0] REG_CONTROL = 12'hB02;
  localparam logic [11:0] REG_SAVE    = 12'hB03;
  localparam logic [11:0] REG_COMMIT  = 12'h232;
  localparam logic [11:0] SEG_BASE    = 12'hA00;

  // Field positions
  localparam int BIT_BUSY   = 0;
  localparam int BIT_ERR    = 0;
  localparam int BIT_WR_EN  = 0;
  localparam int BIT_SOFT   = 1;
  localparam int BIT_SAVE   = 0;
  localparam int BIT_COMMIT = 0;
  localparam int BIT_OPCODE = 7;

  // Reset values
  localparam logic       WR_EN_RST = 1'b0;
  localparam logic       PIN_RST   = 1'b1;
  localparam logic [7:0] BYTE_RST  = 8'h00;

  // Segment operation codes
  localparam logic [7:0] OP_IO_UPDATE = 8'h80;
  localparam logic [7:0] OP_END       = 8'hFF;

  // Host spacing between transfers
  localparam int CLK_MHZ         = 40;
  localparam int HOLDOFF_US      = 10;
  localparam int HOLDOFF_CYCLES  = HOLDOFF_US * CLK_MHZ;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_CMD   = 3'h1,
    ST_AHI   = 3'h2,
    ST_ALO   = 3'h3,
    ST_DATA  = 3'h4,
    ST_CHECK = 3'h5
  } xfer_state_t;

endpackage

// File: verilog/pin_filter.sv
`timescale 1ns/1ps
module pin_filter
  import nv_store_pkg::*;
#(
  parameter logic RST_VAL = PIN_RST
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic pin,
  output logic      level
);

  logic s1;
  logic s2;
  logic s3;

  // A change is taken only once the last two stages agree
  always_ff @(posedge clk) begin
    if (rst) begin
      s1    <= RST_VAL;
      s2    <= RST_VAL;
      s3    <= RST_VAL;
      level <= RST_VAL;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level <= s3;
      end
    end
  end

endmodule // pin_filter

// File: sim/buffer_bank_model.sv
`timescale 1ns/1ps
module buffer_bank_model (
  // Bank access from the controller
  input  wire logic        clk,
  input  wire logic [11:0] addr,
  input  wire logic        we,
  input  wire logic [7:0]  wdata,
  output logic      [7:0]  rdata
);
  logic [7:0] mem [0:4095];
  initial begin
    for (int i = 0; i < 4096; i++) begin
      mem[i] = 8'h00;
    end
  end
  // Read is combinational: the controller consumes data in the cycle the address shows
  assign rdata = mem[addr];
  always @(posedge clk) begin
    if (we === 1'b1) begin
      mem[addr] <= wdata;
    end
  end
endmodule // buffer_bank_model

// File: sim/nv_store_ctrl_monitor.sv
`timescale 1ns/1ps
module nv_store_ctrl_monitor
  import nv_store_pkg::*;
#(
  parameter int NV_AW = 9
) (
  // Clock, reset and register port
  input wire logic              MCLK,
  input wire logic              RST,
  input wire logic [ADDR_W-1:0] REG_ADDR,
  input wire logic              REG_WR,
  input wire logic [DATA_W-1:0] REG_WDATA,
  input wire logic              REG_RD,
  input wire logic [DATA_W-1:0] REG_RDATA,
  // Pins and strobes
  input wire logic              NV_LOAD_SEL_N,
  input wire logic              STATUS_SRC_NV,
  input wire logic              STATUS_OUT,
  input wire logic [ADDR_W-1:0] BUF_ADDR,
  input wire logic [DATA_W-1:0] BUF_RDATA,
  input wire logic [DATA_W-1:0] BUF_WDATA,
  input wire logic              BUF_WE,
  input wire logic              COMMIT,
  input wire logic              SOFT_RESET
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  a_commit_pulse: assert property (
    REG_WR && REG_ADDR == REG_COMMIT && REG_WDATA[BIT_COMMIT] |=> COMMIT)
    else $error("commit strobe missing");
  a_commit_single: assert property (COMMIT |=> !COMMIT)
    else $error("commit strobe too long");
  a_soft_single: assert property (SOFT_RESET |=> !SOFT_RESET)
    else $error("soft reset too long");
  a_soft_cause: assert property (
    $rose(SOFT_RESET) |-> $past(REG_WR && REG_ADDR == REG_CONTROL))
    else $error("soft reset without request");
  a_state_bits: assert property (
    REG_RD && REG_ADDR == REG_STATE |=> REG_RDATA[7:1] == 7'h00)
    else $error("state upper bits set");
  a_error_bits: assert property (
    REG_RD && REG_ADDR == REG_ERROR |=> REG_RDATA[7:1] == 7'h00)
    else $error("error upper bits set");
  a_status_gate: assert property (!STATUS_SRC_NV |=> !STATUS_OUT)
    else $error("status pin driven while deselected");
  a_status_busy: assert property (
    STATUS_SRC_NV && REG_RD && REG_ADDR == REG_STATE |=> STATUS_OUT == REG_RDATA[0])
    else $error("status pin disagrees with busy bit");
  a_rdata_hold: assert property (!REG_RD |=> $stable(REG_RDATA))
    else $error("read data changed without read");
endmodule // nv_store_ctrl_monitor
bind nv_store_ctrl nv_store_ctrl_monitor #(.NV_AW(NV_AW)) nv_store_ctrl_monitor_i (
  .MCLK(MCLK), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_WDATA(REG_WDATA),
  .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .NV_LOAD_SEL_N(NV_LOAD_SEL_N),
  .STATUS_SRC_NV(STATUS_SRC_NV), .STATUS_OUT(STATUS_OUT), .BUF_ADDR(BUF_ADDR),
  .BUF_RDATA(BUF_RDATA), .BUF_WDATA(BUF_WDATA), .BUF_WE(BUF_WE), .COMMIT(COMMIT),
  .SOFT_RESET(SOFT_RESET));

// File: sim/nv_store_ctrl_tb.sv
`timescale 1ns/1ps
module nv_store_ctrl_tb;
  import nv_store_pkg::*;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [11:0] reg_addr = 12'h000;
  logic        reg_wr = 1'b0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_rdata;
  logic        load_sel_n = 1'b1;
  logic        src_nv = 1'b0;
  logic        status_out, buf_we, commit, soft_reset;
  logic [11:0] buf_addr;
  logic [7:0]  buf_rdata, buf_wdata;
  int err_total = 0;
  int total_checks = 0;
  int n_commit = 0;
  int n_soft = 0;
  always #12.5 mclk = ~mclk;
  always @(posedge mclk) begin
    if (commit === 1'b1) n_commit++;
    if (soft_reset === 1'b1) n_soft++;
  end
  // Small memory keeps the overflow case short
  nv_store_ctrl #(.NV_AW(6)) nv_store_ctrl_i (
    .MCLK(mclk), .RST(rst), .REG_ADDR(reg_addr), .REG_WR(reg_wr), .REG_WDATA(reg_wdata),
    .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .NV_LOAD_SEL_N(load_sel_n),
    .STATUS_SRC_NV(src_nv), .STATUS_OUT(status_out), .BUF_ADDR(buf_addr),
    .BUF_RDATA(buf_rdata), .BUF_WDATA(buf_wdata), .BUF_WE(buf_we), .COMMIT(commit),
    .SOFT_RESET(soft_reset));
  buffer_bank_model buffer_bank_model_i (
    .clk(mclk), .addr(buf_addr), .we(buf_we), .wdata(buf_wdata), .rdata(buf_rdata));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [7:0] exp, input string what);
    rd(a);
    chk(what, exp, reg_rdata);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Polls busy; a hung transfer ends the run instead of stalling it
  task automatic wait_idle();
    for (int i = 0; i < 500; i++) begin
      rd(REG_STATE);
      if (reg_rdata === 8'h00) return;
    end
    err_total++;
    $display("BAD wait_idle expected %h seen %h", 8'h00, reg_rdata);
    report_and_stop();
  endtask
  initial begin
    repeat (6) @(posedge mclk);
    buffer_bank_model_i.mem[12'hA00] = 8'h01;
    buffer_bank_model_i.mem[12'hA02] = 8'h10;
    buffer_bank_model_i.mem[12'hA03] = OP_IO_UPDATE;
    buffer_bank_model_i.mem[12'hA04] = OP_END;
    buffer_bank_model_i.mem[12'h010] = 8'h5A;
    buffer_bank_model_i.mem[12'h011] = 8'hA5;
    rst <= 1'b0;
    rdc(REG_STATE, 8'h00, "state idle");
    rdc(REG_ERROR, 8'h00, "error clear");
    rdc(REG_CONTROL, 8'h00, "control reset");
    rdc(12'h7FF, 8'h00, "unmapped");
    @(posedge mclk) src_nv <= 1'b1;
    wr(REG_SAVE, 8'h01);
    rdc(REG_SAVE, 8'h00, "save blocked");
    rdc(REG_STATE, 8'h00, "no save started");
    wr(REG_CONTROL, 8'h03);
    rdc(REG_CONTROL, 8'h01, "reload refused with pin high");
    wr(REG_SAVE, 8'h01);
    rdc(REG_STATE, 8'h01, "busy on save");
    chk("status pin", 8'h01, {7'h00, status_out});
    rdc(REG_SAVE, 8'h01, "save running");
    wait_idle();
    rdc(REG_SAVE, 8'h00, "save self-clear");
    rdc(REG_ERROR, 8'h00, "save no error");
    repeat (HOLDOFF_CYCLES) @(posedge mclk);
    buffer_bank_model_i.mem[12'h010] = 8'h00;
    buffer_bank_model_i.mem[12'h011] = 8'h00;
    load_sel_n <= 1'b0;
    repeat (5) @(posedge mclk);
    wr(REG_CONTROL, 8'h03);
    wait_idle();
    chk("reloaded byte 0", 8'h5A, buffer_bank_model_i.mem[12'h010]);
    chk("reloaded byte 1", 8'hA5, buffer_bank_model_i.mem[12'h011]);
    chk("soft reset count", 8'h01, 8'(n_soft));
    chk("opcode commit count", 8'h01, 8'(n_commit));
    rdc(REG_CONTROL, 8'h01, "soft self-clear");
    rdc(REG_ERROR, 8'h00, "reload no error");
    wr(REG_COMMIT, 8'h01);
    #1 chk("commit strobe", 8'h01, {7'h00, commit});
    rdc(REG_COMMIT, 8'h00, "commit reads 0");
    // Protect lands after the first byte: the stored sum no longer matches
    repeat (HOLDOFF_CYCLES) @(posedge mclk);
    buffer_bank_model_i.mem[12'hA00] = 8'h00;
    buffer_bank_model_i.mem[12'h010] = 8'h00;
    wr(REG_SAVE, 8'h01);
    wr(REG_CONTROL, 8'h00);
    wait_idle();
    rdc(REG_CONTROL, 8'h00, "protect mid-save");
    repeat (HOLDOFF_CYCLES) @(posedge mclk);
    wr(REG_CONTROL, 8'h02);
    wait_idle();
    rdc(REG_ERROR, 8'h01, "bad check byte");
    chk("reload after bad save", 8'h5A, buffer_bank_model_i.mem[12'h010]);
    chk("soft reset count 2", 8'h02, 8'(n_soft));
    wr(REG_CONTROL, 8'h01);
    repeat (HOLDOFF_CYCLES) @(posedge mclk);
    buffer_bank_model_i.mem[12'hA00] = 8'h7F;
    wr(REG_SAVE, 8'h01);
    wait_idle();
    rdc(REG_ERROR, 8'h01, "overflow error");
    rdc(REG_SAVE, 8'h00, "trigger clear after error");
    report_and_stop();
  end
endmodule // nv_store_ctrl_tb
